// [rtl/hib_pkg.sv]
// Purpose: constants and types for the host bridge status and programmed write path.
// Assumes: everything runs on the bus clock; the option shares that clock.
// Notes: register offsets are byte addresses on the plain register port.
// Operation
// - interrupt output low when any status bit is also set in the mask.
// - transmit and receive dma failures set bits 31 and 30, zero write clears.
// - table entry loaded at page boundary sets bit 29 (tx) or 27 (rx).
// - page boundary with table pointer zero sets bit 28 (tx) or 26 (rx).
// - word counter reaching zero sets bit 25 (tx) or 24 (rx).
// - bus parity error sets bit 23 until written zero.
// - bits 11 and 10 show transmit fifo empty and not empty.
// - bits 9 and 8 show receive fifo empty and not empty.
// - bits 7:6 show synchronised transmit unpack position.
// - bits 5:4 show synchronised receive pack position.
// - bits 3:0 read the inverted general input pins.
// - receive window read returns next outgoing word without popping.
// - empty receive fifo with partial dma end returns packer word instead.
// - transmit window write enqueues the word into the transmit fifo.
// - option conflict with ready is passed on with bus ready.
// - after select and write, latch address and mask, drive short address.
// - third cycle assert option select and write, drive address or raw word.
// - fourth cycle drive write data when address enable dropped, others held.
// - cycle after option ready assert bus ready, drop option select.
// - one cycle later drop bus ready and conflict; master ends cycle.
// - mask register resets to zero, all sources disabled.
// - parity checking only while the parity enable bit is set.
package hib_pkg;
  localparam int REG_ADDR_W = 8;
  localparam logic [7:0] OFF_INT_STATUS = 8'h00;
  localparam logic [7:0] OFF_INT_MASK = 8'h04;
  localparam logic [7:0] OFF_RX_PEEK = 8'h08;
  localparam logic [7:0] OFF_TX_FILL = 8'h0c;
  localparam logic [7:0] OFF_CONTROL = 8'h10;
  // flag field: bits 31:23 of the status word
  localparam int FLAG_LSB = 23;
  localparam int FLAG_W = 9;
  localparam int BIT_TX_DMA_ERR = 8;
  localparam int BIT_RX_DMA_ERR = 7;
  localparam int BIT_TX_TABLE_LD = 6;
  localparam int BIT_TX_PAGE_NT = 5;
  localparam int BIT_RX_TABLE_LD = 4;
  localparam int BIT_RX_PAGE_NT = 3;
  localparam int BIT_TX_CNT_ZERO = 2;
  localparam int BIT_RX_CNT_ZERO = 1;
  localparam int BIT_PARITY = 0;
  localparam int RSVD_W = 11;
  localparam int POS_W = 2;
  localparam int GPI_W = 4;
  localparam int SYNC_W = 8;
  localparam int CTL_PARITY_EN = 0;
  localparam int CTL_SAME_CLOCK = 1;
  localparam int SHORT_ADDR_W = 20;
  localparam int FULL_ADDR_W = 27;
  localparam int BM_W = 4;
  localparam logic [FLAG_W-1:0] FLAG_RESET = 9'h000;
  localparam logic [31:0] MASK_RESET = 32'h0000_0000;
  localparam logic [31:0] TABLE_PTR_ZERO = 32'h0000_0000;
  typedef enum logic [2:0] {
    PIO_IDLE = 3'h0,
    PIO_ADDR = 3'h1,
    PIO_SEL = 3'h2,
    PIO_DATA = 3'h3,
    PIO_WAIT = 3'h4,
    PIO_DONE = 3'h5,
    PIO_RACK = 3'h6
  } hib_pio_state_type;
endpackage

// [rtl/hib_bridge.sv]
// Purpose: status/interrupt register, fifo windows and programmed write forwarding.
// Assumes: option and system bus share clk; fifo state comes from same-clock logic.
// Notes: pack positions and input pins come from other timing and are filtered.
`timescale 1ns/100ps

module hib_sync #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] out_q;

  // a bit changes only once stages two and three agree
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      out_q <= '0;
    end else if (clk_en) begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      out_q <= (s2_q & ~(s2_q ^ s3_q)) | (out_q & (s2_q ^ s3_q));
    end
  end

  assign sync_out = out_q;
endmodule

module hib_bridge
  import hib_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [REG_ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic sys_int_n,
  input wire logic tx_dma_fail,
  input wire logic rx_dma_fail,
  input wire logic tx_page_boundary,
  input wire logic rx_page_boundary,
  input wire logic tx_table_entry_load,
  input wire logic rx_table_entry_load,
  input wire logic [31:0] tx_table_pointer,
  input wire logic [31:0] rx_table_pointer,
  input wire logic tx_count_reached_zero,
  input wire logic rx_count_reached_zero,
  input wire logic bus_parity_error,
  input wire logic tx_fifo_empty,
  input wire logic rx_fifo_empty,
  input wire logic [POS_W-1:0] tx_unpack_position,
  input wire logic [POS_W-1:0] rx_pack_position,
  input wire logic [GPI_W-1:0] general_input_pins_n,
  input wire logic [31:0] rx_fifo_head_word,
  input wire logic [31:0] rx_packer_word,
  input wire logic rx_partial_word,
  output logic tx_fifo_push,
  output logic [31:0] tx_fifo_push_data,
  input wire logic sys_sel_n,
  input wire logic sys_write_n,
  input wire logic [31:0] sys_ad_in,
  input wire logic [BM_W-1:0] sys_byte_mask_n,
  output logic [31:0] sys_ad_out,
  output logic sys_ad_oe,
  output logic sys_ready_n,
  output logic sys_conflict_n,
  input wire logic option_same_clock,
  output logic option_select_n,
  output logic option_write_n,
  input wire logic option_ready_n,
  input wire logic option_conflict_n,
  output logic [SHORT_ADDR_W-1:0] option_short_address,
  output logic [BM_W-1:0] option_byte_mask_n,
  output logic [31:0] option_muxed_bus_out,
  output logic option_muxed_bus_oe,
  input wire logic [31:0] option_muxed_bus_in,
  input wire logic option_address_enable_n,
  input wire logic option_io_enable_n,
  input wire logic option_bus_drive_enable_n
);
  logic [FLAG_W-1:0] flag_q;
  logic [FLAG_W-1:0] flag_d;
  logic [FLAG_W-1:0] flag_set;
  logic [31:0] mask_q;
  logic parity_check_enable_q;
  logic [31:0] status_word;
  logic [31:0] peek_word;
  logic [31:0] read_mux;
  logic [31:0] rdata_q;
  logic int_n_q;
  logic push_q;
  logic [31:0] push_data_q;
  logic [SYNC_W-1:0] sync_raw;
  logic [SYNC_W-1:0] sync_val;
  logic [POS_W-1:0] tx_unpack_position_sync;
  logic [POS_W-1:0] rx_pack_position_sync;
  logic [GPI_W-1:0] gpi_sync_n;
  logic wr_status;
  hib_pio_state_type state_q;
  hib_pio_state_type state_d;
  logic [31:0] addr_q;
  logic [BM_W-1:0] bm_q;
  logic [31:0] wdata_q;
  logic conflict_q;
  logic addr_phase_ok;
  logic data_phase_ok;

  // positions and pins are filtered; the positions are only trustworthy while the
  // matching fifo side is idle, software has to respect that
  assign sync_raw = {tx_unpack_position, rx_pack_position, general_input_pins_n};

  hib_sync #(.W(SYNC_W)) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .async_in(sync_raw),
    .sync_out(sync_val)
  );

  assign tx_unpack_position_sync = sync_val[GPI_W+POS_W +: POS_W];
  assign rx_pack_position_sync = sync_val[GPI_W +: POS_W];
  assign gpi_sync_n = sync_val[GPI_W-1:0];

  // event sources for the sticky flags
  always_comb begin
    flag_set = '0;
    flag_set[BIT_TX_DMA_ERR] = tx_dma_fail;
    flag_set[BIT_RX_DMA_ERR] = rx_dma_fail;
    flag_set[BIT_TX_TABLE_LD] = tx_page_boundary && tx_table_entry_load;
    flag_set[BIT_RX_TABLE_LD] = rx_page_boundary && rx_table_entry_load;
    flag_set[BIT_TX_PAGE_NT] = tx_page_boundary && (tx_table_pointer == TABLE_PTR_ZERO);
    flag_set[BIT_RX_PAGE_NT] = rx_page_boundary && (rx_table_pointer == TABLE_PTR_ZERO);
    flag_set[BIT_TX_CNT_ZERO] = tx_count_reached_zero;
    flag_set[BIT_RX_CNT_ZERO] = rx_count_reached_zero;
    flag_set[BIT_PARITY] = bus_parity_error && parity_check_enable_q;
  end

  assign wr_status = reg_wr && (reg_addr == OFF_INT_STATUS);

  // a zero clears, a one is ignored, and a new event beats a same-cycle clear
  always_comb begin
    flag_d = flag_q;
    if (wr_status) begin
      flag_d = flag_q & reg_wdata[FLAG_LSB +: FLAG_W];
    end
    flag_d = flag_d | flag_set;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flag_q <= FLAG_RESET;
    end else if (clk_en) begin
      flag_q <= flag_d;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mask_q <= MASK_RESET;
      parity_check_enable_q <= 1'b0;
    end else if (clk_en && reg_wr) begin
      if (reg_addr == OFF_INT_MASK) begin
        mask_q <= reg_wdata;
      end
      if (reg_addr == OFF_CONTROL) begin
        parity_check_enable_q <= reg_wdata[CTL_PARITY_EN];
      end
    end
  end

  // read-only fields come from live fifo state and the filtered positions and pins; writes never reach them
  assign status_word = {flag_q,
                        {RSVD_W{1'b0}},
                        tx_fifo_empty, !tx_fifo_empty,
                        rx_fifo_empty, !rx_fifo_empty,
                        tx_unpack_position_sync,
                        rx_pack_position_sync,
                        ~gpi_sync_n};

  // peek never pops; a partial packer word stands in for an empty fifo
  assign peek_word = (rx_fifo_empty && rx_partial_word) ? rx_packer_word
                                                        : rx_fifo_head_word;

  always_comb begin
    read_mux = 32'h0000_0000;
    unique case (reg_addr)
      OFF_INT_STATUS: read_mux = status_word;
      OFF_INT_MASK: read_mux = mask_q;
      OFF_RX_PEEK: read_mux = peek_word;
      OFF_CONTROL: begin
        read_mux[CTL_PARITY_EN] = parity_check_enable_q;
        read_mux[CTL_SAME_CLOCK] = option_same_clock;
      end
      default: read_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_q <= 32'h0000_0000;
    end else if (clk_en) begin
      rdata_q <= reg_rd ? read_mux : 32'h0000_0000;
    end
  end

  assign reg_rdata = rdata_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      int_n_q <= 1'b1;
    end else if (clk_en) begin
      int_n_q <= ~|(status_word & mask_q);
    end
  end

  assign sys_int_n = int_n_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      push_q <= 1'b0;
      push_data_q <= 32'h0000_0000;
    end else if (clk_en) begin
      push_q <= reg_wr && (reg_addr == OFF_TX_FILL);
      if (reg_wr && (reg_addr == OFF_TX_FILL)) begin
        push_data_q <= reg_wdata;
      end
    end
  end

  assign tx_fifo_push = push_q;
  assign tx_fifo_push_data = push_data_q;

  // programmed write forwarding; reads are answered at once with zero data
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      PIO_IDLE: begin
        if (!sys_sel_n) begin
          state_d = sys_write_n ? PIO_RACK : PIO_ADDR;
        end
      end
      PIO_ADDR: state_d = PIO_SEL;
      PIO_SEL: state_d = PIO_DATA;
      PIO_DATA: state_d = option_ready_n ? PIO_WAIT : PIO_DONE;
      PIO_WAIT: begin
        if (!option_ready_n) begin
          state_d = PIO_DONE;
        end
      end
      PIO_DONE: state_d = PIO_IDLE;
      PIO_RACK: state_d = PIO_IDLE;
      default: state_d = PIO_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= PIO_IDLE;
    end else if (clk_en) begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      addr_q <= 32'h0000_0000;
      bm_q <= '1;
      wdata_q <= 32'h0000_0000;
    end else if (clk_en) begin
      if (state_q == PIO_IDLE && !sys_sel_n && !sys_write_n) begin
        addr_q <= sys_ad_in;
        bm_q <= sys_byte_mask_n;
      end
      if (state_q == PIO_ADDR) begin
        wdata_q <= sys_ad_in;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      conflict_q <= 1'b0;
    end else if (clk_en) begin
      if ((state_q == PIO_DATA || state_q == PIO_WAIT) && !option_ready_n) begin
        conflict_q <= !option_conflict_n;
      end else if (state_q == PIO_DONE) begin
        conflict_q <= 1'b0;
      end
    end
  end

  assign option_short_address = addr_q[SHORT_ADDR_W-1:0];
  assign option_byte_mask_n = bm_q;
  assign addr_phase_ok = !option_address_enable_n && !option_io_enable_n && !option_bus_drive_enable_n;
  assign data_phase_ok = option_address_enable_n && !option_io_enable_n && !option_bus_drive_enable_n;

  always_comb begin
    option_muxed_bus_out = 32'h0000_0000;
    option_muxed_bus_oe = 1'b0;
    if (state_q == PIO_SEL) begin
      option_muxed_bus_oe = 1'b1;
      option_muxed_bus_out = addr_phase_ok ? {{(32-FULL_ADDR_W){1'b0}}, addr_q[FULL_ADDR_W-1:0]}
                                           : addr_q;
    end else if ((state_q == PIO_DATA || state_q == PIO_WAIT) && data_phase_ok) begin
      option_muxed_bus_oe = 1'b1;
      option_muxed_bus_out = wdata_q;
    end
  end

  // select ends in the ready cycle, so the option sees exactly one ready handshake
  assign option_select_n = !(state_q == PIO_SEL || state_q == PIO_DATA || state_q == PIO_WAIT);
  assign option_write_n = option_select_n;
  assign sys_ready_n = !(state_q == PIO_DONE || state_q == PIO_RACK);
  assign sys_conflict_n = !(state_q == PIO_DONE && conflict_q);
  assign sys_ad_out = 32'h0000_0000;
  assign sys_ad_oe = (state_q == PIO_RACK);

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n || !clk_en);

  sequence pio_write_start;
    state_q == PIO_IDLE && !sys_sel_n && !sys_write_n;
  endsequence

  sequence option_answers;
    (state_q == PIO_DATA || state_q == PIO_WAIT) && !option_ready_n;
  endsequence

  int_output_a: assert property ($past(rst_n) |-> sys_int_n == !$past(|(status_word & mask_q)))
    else $error("interrupt output disagrees with masked status");
  tx_error_set_a: assert property (tx_dma_fail |=> flag_q[BIT_TX_DMA_ERR])
    else $error("transmit dma error flag not set");
  flag_held_a: assert property (flag_q[BIT_RX_DMA_ERR] && !(wr_status && !reg_wdata[FLAG_LSB+BIT_RX_DMA_ERR])
                                |=> flag_q[BIT_RX_DMA_ERR])
    else $error("receive dma error flag lost without zero write");
  table_load_a: assert property (rx_page_boundary && rx_table_entry_load |=> flag_q[BIT_RX_TABLE_LD])
    else $error("receive table load flag not set");
  page_no_table_a: assert property (tx_page_boundary && tx_table_pointer == TABLE_PTR_ZERO
                                    |=> flag_q[BIT_TX_PAGE_NT])
    else $error("transmit page flag not set");
  count_zero_a: assert property (tx_count_reached_zero |=> flag_q[BIT_TX_CNT_ZERO])
    else $error("transmit count flag not set");
  parity_gate_a: assert property (!flag_q[BIT_PARITY] && !parity_check_enable_q |=> !flag_q[BIT_PARITY])
    else $error("parity flag set while checking disabled");
  fifo_state_a: assert property (status_word[11] == tx_fifo_empty && status_word[10] != status_word[11]
                                 && status_word[9] != status_word[8])
    else $error("fifo state bits not complementary");
  status_read_a: assert property (reg_rd && reg_addr == OFF_INT_STATUS
                                  |=> reg_rdata == $past(status_word) && reg_rdata[22:12] == 0)
    else $error("status read wrong");
  peek_read_a: assert property (reg_rd && reg_addr == OFF_RX_PEEK |=> reg_rdata == $past(peek_word))
    else $error("receive window read wrong");
  tx_push_a: assert property (reg_wr && reg_addr == OFF_TX_FILL
                              |=> tx_fifo_push && tx_fifo_push_data == $past(reg_wdata))
    else $error("transmit window write not pushed");
  write_steps_a: assert property (pio_write_start |=> option_short_address == $past(sys_ad_in[19:0])
                                  ##1 !option_select_n && !option_write_n && option_muxed_bus_oe)
    else $error("programmed write start sequence wrong");
  ready_pass_a: assert property (option_answers |=> !sys_ready_n && option_select_n
                                 ##1 sys_ready_n && sys_conflict_n)
    else $error("bus ready handshake wrong");
  conflict_pass_a: assert property (option_answers and !option_conflict_n |=> !sys_conflict_n)
    else $error("conflict not passed to bus");
endmodule

// [tb/hib_option_model.sv]
// Purpose: behavioural option controller facing the programmed write path.
// Assumes: option runs from the bus clock.
// Notes: wait length, conflict and raw-address mode are set by the bench per transfer.
`timescale 1ns/100ps

module hib_option_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [1:0] extra_wait,
  input wire logic want_conflict,
  input wire logic raw_address,
  input wire logic option_select_n,
  input wire logic [31:0] option_muxed_bus_out,
  output logic option_same_clock,
  output logic option_ready_n,
  output logic option_conflict_n,
  output logic option_address_enable_n,
  output logic option_io_enable_n,
  output logic option_bus_drive_enable_n,
  output logic [31:0] write_data_q
);
  logic [2:0] sel_cycles_q;
  logic sel;
  assign sel = !option_select_n;
  assign option_same_clock = 1'b1;
  // address phase only in the first selected cycle; raw mode refuses it to get the plain bus word
  assign option_address_enable_n = !(sel && sel_cycles_q == 3'h0 && !raw_address);
  assign option_io_enable_n = !sel;
  // released as soon as select drops, so the bus is never held past the ready cycle
  assign option_bus_drive_enable_n = !sel;
  assign option_ready_n = !(sel && sel_cycles_q == 3'h2 + {1'b0, extra_wait});
  assign option_conflict_n = option_ready_n || !want_conflict;
  always @(posedge clk) begin
    if (!rst_n || !sel)
      sel_cycles_q <= 3'h0;
    else
      sel_cycles_q <= sel_cycles_q + 3'h1;
  end
  always @(posedge clk) begin
    if (!option_ready_n)
      write_data_q <= option_muxed_bus_out;
  end
endmodule

// [tb/tb.sv]
// Purpose: self-checking bench for the host bridge status register and programmed write path.
// Assumes: clk_en held high; option shares the bus clock.
// Notes: flag cases run from a table; reset and write transfers are hand-written.
`timescale 1ns/100ps

module tb
  import hib_pkg::*;
;
  typedef struct {logic [8:0] ev; logic [31:0] exp;} hib_row_type;
  hib_row_type rows [9] = '{'{9'h100, 32'h8000_0000}, '{9'h080, 32'h4000_0000}, '{9'h040, 32'h2000_0000},
    '{9'h020, 32'h1000_0000}, '{9'h010, 32'h0800_0000}, '{9'h008, 32'h0400_0000},
    '{9'h004, 32'h0200_0000}, '{9'h002, 32'h0100_0000}, '{9'h001, 32'h0080_0000}};
  logic clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, ad_in = 32'h0, rx_head = 32'h0, rx_packer = 32'h0, d;
  logic [8:0] ev = 9'h000;
  logic tx_fifo_empty = 1'b1, rx_fifo_empty = 1'b1, partial = 1'b0, sel_n = 1'b1, write_n = 1'b1;
  logic [1:0] tx_pos = 2'h0, rx_pos = 2'h0, extra_wait = 2'h0;
  logic [3:0] gpi_n = 4'hf, bm_n = 4'hf, opt_bm_n;
  logic want_conflict = 1'b0, raw_address = 1'b0;
  logic [31:0] reg_rdata, push_data, mux_out, opt_data, ad_out;
  logic sys_int_n, push, ready_n, conflict_n, opt_sel_n, opt_wr_n, mux_oe, same_clock, ad_oe;
  logic opt_rdy_n, opt_conf_n, adr_en_n, io_en_n, drv_en_n;
  logic [19:0] short_addr;
  int failures = 0, samples_checked = 0, cycles = 0;

  hib_bridge i_dut (
    .clk(clk), .rst_n(rst_n), .clk_en(1'b1), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sys_int_n(sys_int_n), .tx_dma_fail(ev[8]), .rx_dma_fail(ev[7]),
    .tx_page_boundary(ev[6] | ev[5]), .rx_page_boundary(ev[4] | ev[3]), .tx_table_entry_load(ev[6]),
    .rx_table_entry_load(ev[4]), .tx_table_pointer(ev[5] ? 32'h0 : 32'h1000),
    .rx_table_pointer(ev[3] ? 32'h0 : 32'h1000), .tx_count_reached_zero(ev[2]), .rx_count_reached_zero(ev[1]),
    .bus_parity_error(ev[0]), .tx_fifo_empty(tx_fifo_empty), .rx_fifo_empty(rx_fifo_empty),
    .tx_unpack_position(tx_pos), .rx_pack_position(rx_pos), .general_input_pins_n(gpi_n),
    .rx_fifo_head_word(rx_head), .rx_packer_word(rx_packer), .rx_partial_word(partial), .tx_fifo_push(push),
    .tx_fifo_push_data(push_data), .sys_sel_n(sel_n), .sys_write_n(write_n), .sys_ad_in(ad_in),
    .sys_byte_mask_n(bm_n), .sys_ad_out(ad_out), .sys_ad_oe(ad_oe), .sys_ready_n(ready_n),
    .sys_conflict_n(conflict_n),
    .option_same_clock(same_clock), .option_select_n(opt_sel_n), .option_write_n(opt_wr_n),
    .option_ready_n(opt_rdy_n), .option_conflict_n(opt_conf_n), .option_short_address(short_addr),
    .option_byte_mask_n(opt_bm_n), .option_muxed_bus_out(mux_out), .option_muxed_bus_oe(mux_oe),
    .option_muxed_bus_in(32'h0), .option_address_enable_n(adr_en_n), .option_io_enable_n(io_en_n),
    .option_bus_drive_enable_n(drv_en_n));

  hib_option_model i_option (
    .clk(clk), .rst_n(rst_n), .extra_wait(extra_wait), .want_conflict(want_conflict),
    .raw_address(raw_address), .option_select_n(opt_sel_n), .option_muxed_bus_out(mux_out),
    .option_same_clock(same_clock), .option_ready_n(opt_rdy_n), .option_conflict_n(opt_conf_n),
    .option_address_enable_n(adr_en_n), .option_io_enable_n(io_en_n),
    .option_bus_drive_enable_n(drv_en_n), .write_data_q(opt_data));

  always #25 clk = ~clk;

  task automatic end_of_test();
    if (failures == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // hang guard: the whole sequence needs well under a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      end_of_test();
    end
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", name, exp, got);
      failures++;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 q = reg_rdata;
  endtask

  task automatic fire(input logic [8:0] v);
    @(posedge clk);
    ev <= v;
    @(posedge clk);
    ev <= 9'h000;
  endtask

  task automatic pio(input logic [31:0] a, input logic [31:0] w, input logic [1:0] dly, input logic conf,
                     input logic raw);
    int k;
    k = 0;
    @(posedge clk);
    extra_wait <= dly;
    want_conflict <= conf;
    raw_address <= raw;
    sel_n <= 1'b0;
    write_n <= 1'b0;
    ad_in <= a;
    bm_n <= a[7:4];
    @(posedge clk);
    ad_in <= w;
    #1 chk("short_addr", {12'h0, a[19:0]}, {12'h0, short_addr});
    chk("byte_mask", {28'h0, a[7:4]}, {28'h0, opt_bm_n});
    @(posedge clk);
    #1 chk("opt_sel_wr", 32'h0, {opt_sel_n, opt_wr_n});
    chk("addr_phase", raw ? a : {5'h0, a[26:0]}, mux_oe ? mux_out : ~mux_out);
    @(posedge clk);
    #1 chk("data_phase", w, mux_oe ? mux_out : ~mux_out);
    while (ready_n !== 1'b0 && k < 12) begin
      @(posedge clk);
      #1 k++;
    end
    chk("ready_cycle", 32'(2 + dly), 32'(k));
    chk("conflict", {31'h0, !conf}, {31'h0, conflict_n});
    chk("opt_sel_off", 32'h1, {31'h0, opt_sel_n});
    @(posedge clk);
    sel_n <= 1'b1;
    write_n <= 1'b1;
    ad_in <= ~w;
    #1 chk("ready_off", 32'h3, {30'h0, ready_n, conflict_n});
    chk("opt_data", w, opt_data);
  endtask

  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rd(OFF_INT_MASK, d);
    chk("mask_reset", 32'h0, d);
    wr(OFF_INT_MASK, 32'ha5a5_5a5a);
    wr(8'h20, 32'hffff_ffff);
    rd(OFF_INT_MASK, d);
    chk("mask_rw", 32'ha5a5_5a5a, d);
    rd(8'h20, d);
    chk("unmapped", 32'h0, d);
    for (int i = 0; i < 2; i++) begin
      {tx_fifo_empty, rx_fifo_empty, tx_pos, rx_pos, gpi_n} <= i ? 10'b0_1_01_11_1010 : 10'b1_0_10_01_0101;
      repeat (6) @(posedge clk);
      wr(OFF_INT_STATUS, 32'h0000_0fff);
      rd(OFF_INT_STATUS, d);
      chk("status_low", i ? 32'h675 : 32'h99a, d);
    end
    wr(OFF_CONTROL, 32'h1);
    rd(OFF_CONTROL, d);
    chk("control", 32'h3, d);
    foreach (rows[i]) begin
      fire(rows[i].ev);
      rd(OFF_INT_STATUS, d);
      chk("flag_set", rows[i].exp, d & 32'hff80_0000);
      wr(OFF_INT_MASK, rows[i].exp);
      repeat (2) @(posedge clk);
      #1 chk("int_on", 32'h0, {31'h0, sys_int_n});
      wr(OFF_INT_STATUS, 32'hffff_ffff);
      rd(OFF_INT_STATUS, d);
      chk("flag_kept", rows[i].exp, d & 32'hffff_f000);
      wr(OFF_INT_STATUS, ~rows[i].exp);
      rd(OFF_INT_STATUS, d);
      chk("flag_clr", 32'h0, d & 32'hff80_0000);
      chk("int_off", 32'h1, {31'h0, sys_int_n});
    end
    wr(OFF_CONTROL, 32'h0);
    fire(9'h001);
    rd(OFF_INT_STATUS, d);
    chk("parity_off", 32'h0, d & 32'hff80_0000);
    rx_fifo_empty <= 1'b0;
    rx_head <= 32'h1234_5678;
    rx_packer <= 32'h00ab_cdef;
    partial <= 1'b1;
    repeat (2) begin
      rd(OFF_RX_PEEK, d);
      chk("rx_peek", 32'h1234_5678, d);
    end
    rx_fifo_empty <= 1'b1;
    rd(OFF_RX_PEEK, d);
    chk("rx_packer", 32'h00ab_cdef, d);
    wr(OFF_TX_FILL, 32'hc0de_0001);
    #1 chk("tx_push", 32'h1, {31'h0, push});
    chk("tx_push_data", 32'hc0de_0001, push_data);
    @(posedge clk);
    #1 chk("tx_push_end", 32'h0, {31'h0, push});
    pio(32'hfabc_d123, 32'h5a5a_0f0f, 2'h0, 1'b0, 1'b0);
    pio(32'h0765_4321, 32'h8421_7e7e, 2'h2, 1'b1, 1'b1);
    pio(32'h0000_0ff0, 32'h1111_2222, 2'h1, 1'b1, 1'b0);
    // a bus read is acknowledged at once and never reaches the option
    @(posedge clk);
    sel_n <= 1'b0;
    @(posedge clk);
    #1 chk("read_ack", 32'h3, {29'h0, ready_n, ad_oe, opt_sel_n});
    chk("read_data", 32'h0, ad_out);
    @(posedge clk);
    sel_n <= 1'b1;
    #1 chk("read_end", 32'h2, {30'h0, ready_n, ad_oe});
    wr(OFF_INT_MASK, 32'h7f80_0000);
    fire(9'h100);
    repeat (2) @(posedge clk);
    #1 chk("int_masked", 32'h1, {31'h0, sys_int_n});
    // an event in the same cycle as a zero write must survive it
    @(posedge clk);
    ev <= 9'h002;
    reg_addr <= OFF_INT_STATUS;
    reg_wdata <= 32'h0;
    reg_wr <= 1'b1;
    @(posedge clk);
    ev <= 9'h000;
    reg_wr <= 1'b0;
    rd(OFF_INT_STATUS, d);
    chk("set_beats_clear", 32'h0100_0000, d & 32'hff80_0000);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    #1 chk("reset_outs", 32'h3, {30'h0, sys_int_n, opt_sel_n});
    rd(OFF_INT_MASK, d);
    chk("mask_rereset", 32'h0, d);
    rd(OFF_INT_STATUS, d);
    chk("flags_rereset", 32'h0, d & 32'hff80_0000);
    end_of_test();
  end
endmodule
